// ### inc/adapter_seq_pkg.sv
/*
  Constants, frame kinds and carrier structs for the equipment-side
  command sequencer. Assumes a frame layer that delivers whole decoded
  frames and sends whole frames on request.
*/
package adapter_seq_pkg;
  // ==========================================================
  // Clock and time base
  localparam int CLK_HZ          = 250_000_000;
  localparam int TICK_HZ         = 1000;
  localparam int TICK_CYCLES_DEF = CLK_HZ / TICK_HZ;
  localparam int PRE_W           = 20;
  localparam int MS_W            = 13;
  typedef logic [MS_W-1:0] ms_t;

  // ==========================================================
  // Timeouts in seconds and in ticks
  localparam int MAX_RESPONSE_TIME_S = 3;
  localparam int INIT_WAIT_LIMIT_S   = 6;
  localparam int DISPOSAL_MIN_WAIT_S = 6;
  localparam ms_t MAX_RESP_TICKS = ms_t'(MAX_RESPONSE_TIME_S * TICK_HZ);
  localparam ms_t INIT_WAIT_TICKS = ms_t'(INIT_WAIT_LIMIT_S * TICK_HZ);
  // One extra tick covers the unaligned first tick of a least wait
  localparam ms_t DISPOSAL_TICKS = ms_t'(DISPOSAL_MIN_WAIT_S * TICK_HZ + 1);

  // ==========================================================
  // Retry and error-frequency defaults
  localparam logic [1:0] RETRY_LIMIT_DEF = 2'h3;
  localparam logic [3:0] ERR_LIMIT_DEF   = 4'h4;

  // ==========================================================
  // Frame kinds on the link
  typedef enum logic [3:0] {
    FR_NONE, ST_ACC_REQ, ST_ACC_RSP, ST_NTF_REQ, ST_NTF_RSP,
    OBJ_REQ, OBJ_RSP, COMM_ERR, CONF_REQ, CONF_RSP,
    INIT_DONE_NTF, INIT_DONE_RSP
  } frame_e;

  typedef struct packed {
    logic   valid;
    logic   err;
    frame_e kind;
  } rx_s;

  typedef struct packed {
    logic   valid;
    frame_e kind;
  } tx_s;

  // ==========================================================
  // Whole state of the sequencer
  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic             tick;
    tx_s              tx;
    logic             reqInTx;
    logic             busy;
    logic             reqSend;
    frame_e           reqKind;
    ms_t              reqMs;
    logic [1:0]       tries;
    logic             respPend;
    frame_e           respKind;
    logic             done;
    logic             fail;
    logic [3:0]       errCnt;
    logic             errFreq;
    logic             initWait;
    ms_t              initMs;
    logic             initDone;
    logic             initTimeout;
    logic             disposing;
    ms_t              dispMs;
    logic             disposeDone;
  } state_s;
endpackage

// ### design/equipment_sequencer.sv
/*
  Equipment-side sequencer facing a middleware adapter: answers the
  adapter's requests, originates status notification and object access
  requests with timeout and retry, and times the init and disposal waits.
  Assumes a frame layer that flags receive errors and acknowledges each
  transmitted frame with txAck.
*/
// How it works
// R01 - Adapter expects status access response within three seconds.
// R02 - We answer each status access request within three seconds.
// R03 - Adapter answers our status notification within three seconds.
// R04 - We send status notifications and time out after three seconds.
// R05 - Adapter answers our object access request within three seconds.
// R06 - We send object access requests and time out after three seconds.
// R07 - A received frame with an error is dropped; we send an error frame. We send none while a response is still queued or on the line.
// R08 - An error frame answering our request means resend, like timeout.
// R09 - Adapter drops bad frames from us and sends an error frame.
// R10 - Adapter resends its request when we answer with an error frame.
// R11 - Adapter flags frequent errors in its error properties.
// R12 - Only one own request outstanding until its response arrives.
// R13 - Requests arriving before our pending response is sent are dropped.
// R14 - Adapter answers multi Get from own data without upstream gets.
// R15 - Adapter fetches upstream-get values by status access first.
// R16 - Adapter answers multi Set alone without upstream sets.
// R17 - Adapter forwards upstream-set values by status access first.
// R18 - Adapter finishes initialization within five seconds.
// R19 - We wait at most six seconds for init completion.
// R20 - We answer interface-data confirmation within three seconds.
// R21 - We wait at least six seconds for adapter data disposal.
// R22 - Adapter waits five seconds for confirmation response.
// R23 - Timeouts count a one-millisecond tick, cleared when a request goes out.
`timescale 1ns/10ps
module equipment_sequencer
  import adapter_seq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
  parameter logic [1:0]  RETRY_LIMIT = RETRY_LIMIT_DEF,
  parameter logic [3:0]  ERR_LIMIT   = ERR_LIMIT_DEF
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire rx_s  rxFrame,
  input  wire logic txAck,
  output tx_s       txFrame,
  input  wire logic ntfStart,
  input  wire logic objStart,
  output logic      busy,
  output logic      done,
  output logic      fail,
  input  wire logic initWaitStart,
  output logic      initDone,
  output logic      initTimeout,
  input  wire logic disposeStart,
  output logic      disposeDone,
  input  wire logic errClr,
  output logic      errFreq
);

  // ==========================================================
  // Frame decoding
  // Adapter-originated frames that we must answer
  function automatic logic isReq(input frame_e k);
    return (k == ST_ACC_REQ) || (k == CONF_REQ) || (k == INIT_DONE_NTF);
  endfunction

  // Response kind matching a request kind
  function automatic frame_e rspOf(input frame_e k);
    unique case (k)
      ST_ACC_REQ:    return ST_ACC_RSP;
      ST_NTF_REQ:    return ST_NTF_RSP;
      OBJ_REQ:       return OBJ_RSP;
      CONF_REQ:      return CONF_RSP;
      INIT_DONE_NTF: return INIT_DONE_RSP;
      default:       return FR_NONE;
    endcase
  endfunction

  // ==========================================================
  // Reset release
  logic [1:0] rstSync_q;
  logic       rstN;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstN = rstSync_q[1];

  // ==========================================================
  // Sequencer
  state_s s_q;
  state_s s_d;
  logic   waiting;
  logic   tmo;
  logic   retry;
  logic   bad;
  logic   respBusy;

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.fail = 1'b0;
    s_d.initDone = 1'b0;
    s_d.initTimeout = 1'b0;
    s_d.disposeDone = 1'b0;
    tmo = 1'b0;
    retry = 1'b0;
    bad = 1'b0;
    waiting = s_q.busy && !s_q.reqSend && !s_q.reqInTx;

    // Millisecond tick
    if (s_q.pre == PRE_W'(TICK_CYCLES - 1)) begin // R23
      s_d.pre = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.pre = s_q.pre + PRE_W'(1);
      s_d.tick = 1'b0;
    end

    // Transmit handshake; pending response goes before our request
    if (s_q.tx.valid) begin
      if (txAck) begin
        s_d.tx.valid = 1'b0;
        s_d.reqInTx = 1'b0;
      end
    end else if (s_q.respPend) begin
      s_d.tx = '{valid: 1'b1, kind: s_q.respKind}; // R02 R20
      s_d.respPend = 1'b0;
    end else if (s_q.reqSend) begin
      s_d.tx = '{valid: 1'b1, kind: s_q.reqKind}; // R04 R06
      s_d.reqInTx = 1'b1;
      s_d.reqSend = 1'b0;
      s_d.reqMs = '0; // R23
    end

    // Response timer for our outstanding request
    if (waiting && s_q.tick) begin
      if (s_q.reqMs < MAX_RESP_TICKS) begin
        s_d.reqMs = s_q.reqMs + ms_t'(1); // R23
      end
    end
    if (waiting && s_q.reqMs >= MAX_RESP_TICKS) begin
      tmo = 1'b1; // R04 R06
    end

    // A response is still owed while queued or on the line
    respBusy = s_d.respPend || (s_d.tx.valid && !s_d.reqInTx);

    // Received frames
    if (rxFrame.valid) begin
      if (rxFrame.err) begin
        bad = 1'b1;
        if (!respBusy) begin
          s_d.respPend = 1'b1; // R07
          s_d.respKind = COMM_ERR;
        end
      end else if (rxFrame.kind == COMM_ERR) begin
        if (waiting) begin
          retry = 1'b1; // R08
        end
        bad = 1'b1;
      end else if (isReq(rxFrame.kind)) begin
        if (!respBusy) begin // R13
          s_d.respPend = 1'b1; // R02 R20
          s_d.respKind = rspOf(rxFrame.kind);
          if (rxFrame.kind == INIT_DONE_NTF && s_q.initWait) begin
            s_d.initWait = 1'b0; // R19
            s_d.initDone = 1'b1;
          end
        end
      end else if (waiting && rxFrame.kind == rspOf(s_q.reqKind)) begin
        s_d.busy = 1'b0; // R12
        s_d.done = 1'b1;
        s_d.errCnt = 4'h0;
      end
    end

    // Resend on timeout or error answer, give up past the limit
    if ((tmo || retry) && !s_d.done) begin // R08
      bad = 1'b1;
      if (s_q.tries == RETRY_LIMIT) begin
        s_d.busy = 1'b0;
        s_d.fail = 1'b1;
      end else begin
        s_d.tries = s_q.tries + 2'h1;
        s_d.reqSend = 1'b1;
        s_d.reqMs = '0;
      end
    end

    // Error frequency flag; a new error wins over a clear
    if (bad && s_q.errCnt != 4'hF) begin
      s_d.errCnt = s_q.errCnt + 4'h1;
    end
    if (errClr) begin
      s_d.errFreq = 1'b0;
      s_d.errCnt = bad ? s_d.errCnt : 4'h0;
    end
    if (bad && s_d.errCnt >= ERR_LIMIT) begin
      s_d.errFreq = 1'b1;
    end

    // New own request only when none is outstanding
    if (!s_d.busy && (ntfStart || objStart)) begin // R12
      s_d.busy = 1'b1;
      s_d.reqSend = 1'b1;
      s_d.reqKind = ntfStart ? ST_NTF_REQ : OBJ_REQ;
      s_d.tries = 2'h0;
      s_d.reqMs = '0;
    end

    // Wait for init completion, at most the limit
    if (initWaitStart) begin
      s_d.initWait = 1'b1;
      s_d.initMs = '0;
    end else if (s_q.initWait && s_d.initWait) begin
      if (s_q.initMs >= INIT_WAIT_TICKS) begin
        s_d.initWait = 1'b0; // R19
        s_d.initTimeout = 1'b1;
      end else if (s_q.tick) begin
        s_d.initMs = s_q.initMs + ms_t'(1);
      end
    end

    // Wait for adapter data disposal, at least the limit
    if (disposeStart) begin
      s_d.disposing = 1'b1;
      s_d.dispMs = '0;
    end else if (s_q.disposing) begin
      if (s_q.dispMs >= DISPOSAL_TICKS) begin
        s_d.disposing = 1'b0; // R21
        s_d.disposeDone = 1'b1;
      end else if (s_q.tick) begin
        s_d.dispMs = s_q.dispMs + ms_t'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs straight from state
  assign txFrame     = s_q.tx;
  assign busy        = s_q.busy;
  assign done        = s_q.done;
  assign fail        = s_q.fail;
  assign initDone    = s_q.initDone;
  assign initTimeout = s_q.initTimeout;
  assign disposeDone = s_q.disposeDone;
  assign errFreq     = s_q.errFreq;

endmodule // equipment_sequencer

// ### verification/sequencer_props.sv
/*
  Checker on the sequencer's link and request ports.
  Assumes its far side acks frames and answers requests as the model does.
*/
`timescale 1ns/10ps
module sequencer_props
  import adapter_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire rx_s  rxFrame,
  input wire logic txAck,
  input wire tx_s  txFrame,
  input wire logic ntfStart,
  input wire logic objStart,
  input wire logic busy,
  input wire logic done,
  input wire logic fail
);
  // ==========================================================
  // Helper and assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  frame_e reqQ;
  // Kind of the last own request put on the line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) reqQ <= FR_NONE;
    else if (txFrame.valid && txFrame.kind inside {ST_NTF_REQ, OBJ_REQ}) reqQ <= txFrame.kind;
  end
  tx_hold_a: assert property (txFrame.valid && !txAck |=> txFrame.valid
    && $stable(txFrame.kind)) else $error("frame dropped before ack");
  tx_drop_a: assert property (txFrame.valid && txAck |=> !txFrame.valid)
    else $error("frame held after ack");
  acc_rsp_a: assert property (rxFrame.valid && !rxFrame.err && rxFrame.kind == ST_ACC_REQ
    && !txFrame.valid |-> ##[1:3] (txFrame.valid && txFrame.kind == ST_ACC_RSP))
    else $error("status access not answered");
  err_rsp_a: assert property (rxFrame.valid && rxFrame.err && !txFrame.valid
    |-> ##[1:3] (txFrame.valid && txFrame.kind == COMM_ERR))
    else $error("bad frame not reported");
  conf_rsp_a: assert property (rxFrame.valid && !rxFrame.err && rxFrame.kind == CONF_REQ
    && !txFrame.valid |-> ##[1:3] (txFrame.valid && txFrame.kind == CONF_RSP))
    else $error("confirmation not answered");
  start_busy_a: assert property ((ntfStart || objStart) && !busy |=> busy)
    else $error("start not taken");
  req_sent_a: assert property ($rose(busy) |-> ##[1:6] (txFrame.valid
    && txFrame.kind inside {ST_NTF_REQ, OBJ_REQ})) else $error("request not sent");
  end_pulse_a: assert property ((done || fail) |-> !busy ##1 !(done || fail))
    else $error("end pulse wrong");
  rsp_done_a: assert property (busy && rxFrame.valid && !rxFrame.err
    && rxFrame.kind == frame_e'(reqQ + 4'h1) |=> done) else $error("response missed");
  cover property (done);
  cover property (fail);
  cover property (txFrame.valid && !txAck);
endmodule // sequencer_props

bind equipment_sequencer sequencer_props u_props (.clk(clk), .rst_n(rst_n), .rxFrame(rxFrame),
  .txAck(txAck), .txFrame(txFrame), .ntfStart(ntfStart), .objStart(objStart), .busy(busy),
  .done(done), .fail(fail));

// ### verification/adapter_model.sv
/*
  Adapter model: takes frames, answers the sequencer's own requests.
  Assumes the bench sets mode: 0 right, 1 error frame, 2 silent, 3 slow ack.
*/
`timescale 1ns/10ps
module adapter_model
  import adapter_seq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire tx_s        txFrame,
  input  wire logic [1:0] mode,
  input  wire rx_s        inj,
  output rx_s             rxFrame,
  output logic            txAck
);
  // ==========================================================
  // Link side
  logic seen;
  rx_s  rsp;
  // Ack at once, or one cycle late in slow mode; bench frames win
  assign txAck   = txFrame.valid && (mode != 2'h3 || seen);
  assign rxFrame = inj.valid ? inj : rsp;
  // Answer each taken request one cycle later, except in silent mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen <= 1'b0;
      rsp  <= '0;
    end else begin
      seen <= txFrame.valid && !txAck;
      rsp  <= '0;
      if (txAck && mode != 2'h2 && txFrame.kind inside {ST_NTF_REQ, OBJ_REQ}) begin
        rsp.valid <= 1'b1;
        rsp.kind  <= (mode == 2'h1) ? COMM_ERR : frame_e'(txFrame.kind + 4'h1);
      end
    end
  end
endmodule // adapter_model

// ### verification/adapter_equipment_command_sequencer_test.sv
/*
  Bench for the sequencer with the adapter model on its link.
  Assumes 4-cycle ticks, so a second is 4000 cycles.
*/
`timescale 1ns/10ps
module adapter_equipment_command_sequencer_test
  import adapter_seq_pkg::*;
();
  // ==========================================================
  // Signals and tables
  typedef struct packed { logic o; logic [1:0] m; frame_e k; logic d; } row_s;
  logic       clk = 1'b0, rst_n = 1'b0, txAck, busy, done, fail, initDone, initTo, dDone, errF;
  logic [4:0] st = '0;
  logic [1:0] mode = 2'h0;
  rx_s        inj = '0, rxFrame;
  tx_s        txFrame;
  int         mismatches = 0, num_checks = 0, c;
  row_s       rows [4] = '{'{1'b0, 2'h0, ST_NTF_REQ, 1'b1}, '{1'b1, 2'h0, OBJ_REQ, 1'b1},
                           '{1'b0, 2'h3, ST_NTF_REQ, 1'b1}, '{1'b1, 2'h1, OBJ_REQ, 1'b0}};
  frame_e     iK [3] = '{ST_ACC_REQ, OBJ_RSP, CONF_REQ};
  frame_e     eK [3] = '{ST_ACC_RSP, COMM_ERR, CONF_RSP};
  // Clock and watchdog
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    #400000;
    mismatches++;
    tally_and_finish;
  end
  equipment_sequencer #(.TICK_CYCLES(4)) DUT (.clk(clk), .rst_n(rst_n), .rxFrame(rxFrame),
    .txAck(txAck), .txFrame(txFrame), .ntfStart(st[0]), .objStart(st[1]), .busy(busy),
    .done(done), .fail(fail), .initWaitStart(st[2]), .initDone(initDone),
    .initTimeout(initTo), .disposeStart(st[3]), .disposeDone(dDone), .errClr(st[4]),
    .errFreq(errF));
  adapter_model adapter (.clk(clk), .rst_n(rst_n), .txFrame(txFrame), .mode(mode),
    .inj(inj), .rxFrame(rxFrame), .txAck(txAck));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  function automatic logic ev(input int s);
    case (s)
      0: return txFrame.valid;
      1: return done | fail;
      2: return initTo;
      3: return dDone;
      default: return initDone;
    endcase
  endfunction
  // Bounded wait, c counts the edges passed
  task automatic wait_ev(input int s, input int lim);
    c = 0;
    #1;
    while (ev(s) !== 1'b1 && c < lim) begin
      @(posedge clk);
      #1;
      c++;
    end
    if (ev(s) !== 1'b1) mismatches++;
  endtask
  task automatic pulse(input int s);
    @(posedge clk);
    st[s] <= 1'b1;
    @(posedge clk);
    st <= '0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1 chk({busy, txFrame.valid, done}, 3'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      @(posedge clk);
      mode <= rows[i].m;
      st   <= rows[i].o ? 5'h02 : 5'h01;
      @(posedge clk);
      st <= '0;
      wait_ev(0, 20);
      chk(txFrame.kind, rows[i].k);
      wait_ev(1, 200);
      chk(done, rows[i].d);
    end
    chk(errF, 1'b1);
    pulse(4);
    @(posedge clk);
    #1 chk(errF, 1'b0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      inj <= '{1'b1, i == 1, iK[i]};
      @(posedge clk);
      inj <= '0;
      wait_ev(0, 4);
      chk(txFrame.kind, eK[i]);
    end
    // Second request while the first answer is still queued
    @(posedge clk);
    inj <= '{1'b1, 1'b0, ST_ACC_REQ};
    c = 0;
    @(posedge clk);
    repeat (8) begin
      #1 c += txFrame.valid;
      @(posedge clk);
      inj <= '0;
    end
    chk(c, 1);
    @(posedge clk);
    mode <= 2'h2;
    pulse(0);
    wait_ev(0, 20);
    @(posedge clk);
    mode <= 2'h0;
    wait_ev(0, 13000);
    chk(c > 11990 && c < 12010, 1'b1);
    wait_ev(1, 20);
    chk(done, 1'b1);
    pulse(2);
    wait_ev(2, 25000);
    chk(c > 23995 && c < 24012, 1'b1);
    pulse(2);
    inj <= '{1'b1, 1'b0, INIT_DONE_NTF};
    @(posedge clk);
    inj <= '0;
    wait_ev(4, 5);
    chk(initDone, 1'b1);
    pulse(3);
    wait_ev(3, 25000);
    chk(c > 23999 && c < 24012, 1'b1);
    tally_and_finish;
  end
endmodule // adapter_equipment_command_sequencer_test
